// ---- idsb_map.svh ----
`ifndef IDSB_MAP_SVH
`define IDSB_MAP_SVH
// ----------------------------------------
// Opcode fields of a 14-bit instruction word
// ----------------------------------------
`define IDSB_OP6_MSB 13
`define IDSB_OP6_LSB 8
`define IDSB_OP3_MSB 13
`define IDSB_OP3_LSB 11
`define IDSB_DEST_BIT 7
`define IDSB_FADDR_MSB 6
`define IDSB_BRANCH_MSB 10
`define IDSB_LIT_MSB 7
`define IDSB_FADDR_LSB 0
`define IDSB_BRANCH_LSB 0
`define IDSB_LIT_LSB 0
// ----------------------------------------
// Opcode values
// ----------------------------------------
`define IDSB_OPC_DECSKIP 6'h0b
`define IDSB_OPC_INCSKIP 6'h0f
`define IDSB_OPC_INCREG 6'h0a
`define IDSB_OPC_ORREG 6'h04
`define IDSB_OPC_ORLIT 6'h38
`define IDSB_OPC3_BRANCH 3'h5
// ----------------------------------------
// Program counter layout
// ----------------------------------------
`define IDSB_PCH_MSB 4
`define IDSB_PCH_LSB 3
`define IDSB_PC_RESET 13'h0000
`define IDSB_W_RESET 8'h00
`define IDSB_NOP_WORD 14'h0000
`define IDSB_BIT_RESET 1'h0
`define IDSB_ADDR_RESET 7'h00
`define IDSB_BYTE_ZERO 8'h00
`define IDSB_BYTE_ONE 8'h01
`endif

// ---- idsb_pkg.sv ----
package idsb_pkg;
	typedef enum logic [2:0] {
		IDSB_EXEC = 3'h1,
		IDSB_FLUSH = 3'h2,
		IDSB_IDLE = 3'h4
	} idsb_state_e;

	typedef struct packed {
		logic writeFile;
		logic [6:0] fileAddr;
		logic [7:0] fileData;
	} idsb_fwrite_s;

	typedef struct packed {
		logic load;
		logic [12:0] target;
	} idsb_pcload_s;
endpackage : idsb_pkg

// ---- idsb_exec.sv ----
`timescale 1ns/100ps
`include "idsb_map.svh"
// Function
// - Decrement-skip: file minus one goes to accumulator (d=0) or file (d=1).
// - Zero result from decrement-skip replaces next instruction with no-op, two cycles.
// - Increment-skip: file plus one routed by d; zero result skips next.
// - Increment: file plus one to accumulator or file by d, zero flag updated.
// - Branch: immediate to PC bits 10..0, latch bits 4..3 to PC 12..11.
// - Branch takes immediates 0..2047, two cycles, no status flag change.
// - OR-literal: accumulator OR 8-bit literal into accumulator, zero flag updated.
// - OR-register: accumulator OR file, routed by d, zero flag updated.
module idsb_exec (
	input wire logic clock,
	input wire logic nrst,
	input wire logic instrValid,
	input wire logic [13:0] instrWord,
	input wire logic [7:0] fileReadData,
	input wire logic [7:0] pcHighLatch,
	input wire logic zeroIn,
	output logic [6:0] fileReadAddr,
	output idsb_pkg::idsb_fwrite_s fileWrite,
	output logic [7:0] accumulator,
	output logic zeroFlag,
	output idsb_pkg::idsb_pcload_s pcLoad,
	output logic flushNext,
	output logic busy
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	idsb_pkg::idsb_state_e state;
	idsb_pkg::idsb_state_e next_state;
	logic [7:0] next_accumulator;
	logic next_zeroFlag;
	idsb_pkg::idsb_fwrite_s next_fileWrite;
	idsb_pkg::idsb_pcload_s next_pcLoad;
	logic next_flushNext;
	logic next_busy;
	logic [6:0] next_fileReadAddr;
	logic [13:0] execWord;
	logic [5:0] op6;
	logic [2:0] op3;
	logic destFile;
	logic taken;
	logic isBranch;
	logic isDecSkip;
	logic isIncSkip;
	logic isIncReg;
	logic isOrReg;
	logic isOrLit;
	logic isSkip;
	logic isFileOp;
	logic [7:0] result;
	logic resultZero;
	logic skipTaken;
	logic branchTaken;

	// Flushed slot decodes as the no-op word, whatever the core presents
	assign execWord = (state == idsb_pkg::IDSB_FLUSH) ? `IDSB_NOP_WORD : instrWord;
	assign op6 = execWord[`IDSB_OP6_MSB:`IDSB_OP6_LSB];
	assign op3 = execWord[`IDSB_OP3_MSB:`IDSB_OP3_LSB];
	assign destFile = execWord[`IDSB_DEST_BIT];
	// Taken only outside the flushed slot
	assign taken = instrValid && (state != idsb_pkg::IDSB_FLUSH);

	always_comb begin
		isBranch = (op3 == `IDSB_OPC3_BRANCH);
		isDecSkip = 1'h0;
		isIncSkip = 1'h0;
		isIncReg = 1'h0;
		isOrReg = 1'h0;
		isOrLit = 1'h0;
		case (op6)
			`IDSB_OPC_DECSKIP: begin
				isDecSkip = 1'h1;
			end
			`IDSB_OPC_INCSKIP: begin
				isIncSkip = 1'h1;
			end
			`IDSB_OPC_INCREG: begin
				isIncReg = 1'h1;
			end
			`IDSB_OPC_ORREG: begin
				isOrReg = 1'h1;
			end
			`IDSB_OPC_ORLIT: begin
				isOrLit = 1'h1;
			end
			default: begin
				// Unknown opcodes leave the accumulator, file write and PC load idle
				isOrLit = 1'h0;
			end
		endcase
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	// Read data is combinational; the file bus answers in the same cycle
	always_comb begin
		result = `IDSB_BYTE_ZERO;
		if (isDecSkip) begin
			result = fileReadData - `IDSB_BYTE_ONE;
		end else if (isIncSkip || isIncReg) begin
			result = fileReadData + `IDSB_BYTE_ONE;
		end else if (isOrReg) begin
			result = accumulator | fileReadData;
		end else if (isOrLit) begin
			result = accumulator | execWord[`IDSB_LIT_MSB:`IDSB_LIT_LSB];
		end
	end

	assign resultZero = (result == `IDSB_BYTE_ZERO);
	assign isSkip = isDecSkip || isIncSkip;
	assign isFileOp = isDecSkip || isIncSkip || isIncReg || isOrReg;
	assign skipTaken = taken && isSkip && resultZero;
	assign branchTaken = taken && isBranch;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			idsb_pkg::IDSB_FLUSH: begin
				// Skipped slot or branch refill runs as a no-op
				next_state = idsb_pkg::IDSB_EXEC;
			end
			idsb_pkg::IDSB_EXEC, idsb_pkg::IDSB_IDLE: begin
				if (!instrValid) begin
					next_state = idsb_pkg::IDSB_IDLE;
				end else if (branchTaken || skipTaken) begin
					next_state = idsb_pkg::IDSB_FLUSH;
				end else begin
					next_state = idsb_pkg::IDSB_EXEC;
				end
			end
			default: begin
				next_state = idsb_pkg::IDSB_EXEC;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= idsb_pkg::IDSB_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Accumulator and zero flag
	// ----------------------------------------
	always_comb begin
		next_accumulator = accumulator;
		// Flag follows the core unless an updating instruction is taken
		next_zeroFlag = zeroIn;
		if (taken && !isBranch) begin
			if (isOrLit) begin
				next_accumulator = result;
				next_zeroFlag = resultZero;
			end else if (isFileOp) begin
				if (!destFile) begin
					next_accumulator = result;
				end
				// Skip forms keep the core's zero flag
				if (!isSkip) begin
					next_zeroFlag = resultZero;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			accumulator <= `IDSB_W_RESET;
			zeroFlag <= `IDSB_BIT_RESET;
		end else begin
			accumulator <= next_accumulator;
			zeroFlag <= next_zeroFlag;
		end
	end

	// ----------------------------------------
	// File write
	// ----------------------------------------
	always_comb begin
		next_fileWrite = '0;
		if (taken && isFileOp && destFile) begin
			next_fileWrite.writeFile = 1'h1;
			next_fileWrite.fileAddr = execWord[`IDSB_FADDR_MSB:`IDSB_FADDR_LSB];
			next_fileWrite.fileData = result;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fileWrite <= '0;
		end else begin
			fileWrite <= next_fileWrite;
		end
	end

	// ----------------------------------------
	// Branch
	// ----------------------------------------
	always_comb begin
		next_pcLoad = '0;
		if (branchTaken) begin
			next_pcLoad.load = 1'h1;
			next_pcLoad.target = {pcHighLatch[`IDSB_PCH_MSB:`IDSB_PCH_LSB],
				execWord[`IDSB_BRANCH_MSB:`IDSB_BRANCH_LSB]};
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pcLoad <= '0;
		end else begin
			pcLoad <= next_pcLoad;
		end
	end

	// ----------------------------------------
	// Slot control
	// ----------------------------------------
	// Second cycle drains the prefetched word, so one slot is lost
	always_comb begin
		next_flushNext = 1'h0;
		next_busy = 1'h0;
		if (branchTaken || skipTaken) begin
			next_flushNext = 1'h1;
			next_busy = 1'h1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flushNext <= `IDSB_BIT_RESET;
			busy <= `IDSB_BIT_RESET;
		end else begin
			flushNext <= next_flushNext;
			busy <= next_busy;
		end
	end

	// ----------------------------------------
	// Read address echo
	// ----------------------------------------
	// Informational only; the core must address the file from the word itself
	always_comb begin
		next_fileReadAddr = instrWord[`IDSB_FADDR_MSB:`IDSB_FADDR_LSB];
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fileReadAddr <= `IDSB_ADDR_RESET;
		end else begin
			fileReadAddr <= next_fileReadAddr;
		end
	end
endmodule : idsb_exec

// ---- idsb_exec_checker.sv ----
`timescale 1ns/100ps
`include "idsb_map.svh"
// ----------------
// Execution checks
// ----------------
module idsb_exec_checker (
	input wire logic clock,
	input wire logic nrst,
	input wire logic instrValid,
	input wire logic [13:0] instrWord,
	input wire logic [7:0] fileReadData,
	input wire logic [7:0] pcHighLatch,
	input wire logic zeroIn,
	input wire idsb_pkg::idsb_fwrite_s fileWrite,
	input wire logic [7:0] accumulator,
	input wire logic zeroFlag,
	input wire idsb_pkg::idsb_pcload_s pcLoad,
	input wire logic flushNext,
	input wire logic busy
);
	wire tk = instrValid && !busy;
	wire [5:0] op = instrWord[13:8];
	wire br = tk && instrWord[13:11] == 3'h5;
	wire sq = tk && (op == `IDSB_OPC_DECSKIP || op == `IDSB_OPC_INCSKIP);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	br_target_a: assert property (br |=> pcLoad.load && pcLoad.target ==
		{$past(pcHighLatch[4:3]), $past(instrWord[10:0])}) else $error("bad target");
	br_flush_a: assert property (br |=> flushNext && busy ##1 !busy) else $error("bad slot");
	flag_hold_a: assert property (br || sq |=> zeroFlag == $past(zeroIn)) else $error("flag");
	dec_skip_a: assert property (tk && op == `IDSB_OPC_DECSKIP
		|=> flushNext == ($past(fileReadData) == 8'h01)) else $error("dec skip");
	inc_skip_a: assert property (tk && op == `IDSB_OPC_INCSKIP
		|=> flushNext == ($past(fileReadData) == 8'hff)) else $error("inc skip");
	orl_zero_a: assert property (tk && op == `IDSB_OPC_ORLIT |=> accumulator ==
		$past(accumulator | instrWord[7:0]) && zeroFlag == (accumulator == 8'h00)) else $error("orl");
	inc_file_a: assert property (tk && op == `IDSB_OPC_INCREG && instrWord[7] |=>
		fileWrite.writeFile && fileWrite.fileData == $past(fileReadData + 8'h01)) else $error("inc");
	orr_acc_a: assert property (tk && op == `IDSB_OPC_ORREG && !instrWord[7] |=>
		accumulator == $past(accumulator | fileReadData)) else $error("orr");
	busy_ignore_a: assert property (busy |=> !pcLoad.load && !fileWrite.writeFile) else $error("nop");
	dec_acc_a: assert property (tk && op == `IDSB_OPC_DECSKIP && !instrWord[7] |=>
		accumulator == $past(fileReadData - 8'h01)) else $error("dec acc");
	write_addr_a: assert property (tk && instrWord[7] && (op == `IDSB_OPC_ORREG ||
		op == `IDSB_OPC_DECSKIP) |=> fileWrite.writeFile &&
		fileWrite.fileAddr == $past(instrWord[6:0])) else $error("write addr");
endmodule : idsb_exec_checker
bind idsb_exec idsb_exec_checker u_chk (
	.clock(clock),
	.nrst(nrst),
	.instrValid(instrValid),
	.instrWord(instrWord),
	.fileReadData(fileReadData),
	.pcHighLatch(pcHighLatch),
	.zeroIn(zeroIn),
	.fileWrite(fileWrite),
	.accumulator(accumulator),
	.zeroFlag(zeroFlag),
	.pcLoad(pcLoad),
	.flushNext(flushNext),
	.busy(busy)
);

// ---- tb_idsb_exec.sv ----
`timescale 1ns/100ps
`include "idsb_map.svh"
// ---------
// Testbench
// ---------
module tb_idsb_exec;
	logic clock = 1'h0, nrst = 1'h0, instrValid = 1'h0, zeroIn = 1'h0, tk = 1'h0, vd = 1'h0;
	logic zeroFlag, flushNext, busy;
	logic [13:0] instrWord = 14'h0000, v;
	logic [7:0] fileReadData = 8'h00, pcHighLatch = 8'h00, w = 8'h00, f, accumulator;
	logic [6:0] fileReadAddr;
	logic [47:0] q[$];
	logic [47:0] obs;
	logic [5:0] ops[5] = '{`IDSB_OPC_DECSKIP, `IDSB_OPC_INCSKIP, `IDSB_OPC_INCREG,
		`IDSB_OPC_ORREG, `IDSB_OPC_ORLIT};
	int n_mismatch = 0, cmp_count = 0, seed = 45, i, j;
	idsb_pkg::idsb_fwrite_s fileWrite;
	idsb_pkg::idsb_pcload_s pcLoad;
	idsb_exec dut (
		.clock(clock),
		.nrst(nrst),
		.instrValid(instrValid),
		.instrWord(instrWord),
		.fileReadData(fileReadData),
		.pcHighLatch(pcHighLatch),
		.zeroIn(zeroIn),
		.fileReadAddr(fileReadAddr),
		.fileWrite(fileWrite),
		.accumulator(accumulator),
		.zeroFlag(zeroFlag),
		.pcLoad(pcLoad),
		.flushNext(flushNext),
		.busy(busy)
	);
	initial forever #2 clock = ~clock;
	task chk(input logic [47:0] s, input logic [47:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task end_of_test;
		if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	task ex(input logic [13:0] iw, input logic [7:0] fd);
		logic [5:0] o;
		logic wd, sq, sk, ld, zi, z;
		logic [7:0] r, ph;
		o = iw[13:8];
		zi = 1'($random(seed));
		ph = 8'($random(seed));
		ld = iw[13:11] == 3'h5;
		case (o)
			`IDSB_OPC_DECSKIP: r = fd - 8'h01;
			`IDSB_OPC_ORREG: r = w | fd;
			`IDSB_OPC_ORLIT: r = w | iw[7:0];
			default: r = fd + 8'h01;
		endcase
		wd = !ld && o != `IDSB_OPC_ORLIT && iw[7];
		sq = o == `IDSB_OPC_DECSKIP || o == `IDSB_OPC_INCSKIP;
		sk = sq && r == 8'h00;
		z = (ld || sq) ? zi : r == 8'h00;
		if (!ld && !wd) w = r;
		q.push_back({w, z, wd, wd ? r : 8'h00, wd ? iw[6:0] : 7'h00, sk | ld, sk | ld, ld,
			ld ? {ph[4:3], iw[10:0]} : 13'h0000, iw[6:0]});
		@(posedge clock);
		instrWord <= iw;
		fileReadData <= fd;
		zeroIn <= zi;
		pcHighLatch <= ph;
		instrValid <= 1'h1;
		tk <= 1'h1;
		// Slot after skip or branch: offer a word that must be dropped
		if (sk | ld) begin
			@(posedge clock);
			instrWord <= {`IDSB_OPC_ORLIT, 8'hff};
			tk <= 1'h0;
		end
	endtask : ex
	always @(posedge clock) vd <= tk;
	always @(negedge clock) begin
		obs = {accumulator, zeroFlag, fileWrite.writeFile,
			fileWrite.writeFile ? fileWrite.fileData : 8'h00,
			fileWrite.writeFile ? fileWrite.fileAddr : 7'h00, flushNext, busy, pcLoad.load,
			pcLoad.load ? pcLoad.target : 13'h0000, fileReadAddr};
		if (vd) chk(obs, q.pop_front());
	end
	initial begin
		#8000;
		n_mismatch++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		ex({3'h5, 11'h7ff}, 8'h00);
		ex({3'h5, 11'h000}, 8'h00);
		for (i = 0; i < 300; i++) begin
			j = int'($unsigned($random(seed)) % 6);
			v = 14'($random(seed));
			f = v[1:0] == 2'h0 ? 8'h01 : v[1:0] == 2'h1 ? 8'hff : 8'($random(seed));
			ex(j == 5 ? {3'h5, v[10:0]} : {ops[j], v[7:0]}, f);
		end
		@(posedge clock);
		instrValid <= 1'h0;
		tk <= 1'h0;
		repeat (3) @(posedge clock);
		end_of_test;
	end
endmodule : tb_idsb_exec
